// file: mcu_add_and_bit_ops.sv
// Execution datapath for add, AND, clear and bit operations of an 8-bit core.
//
// How it works
// [RULE_01] Add immediate to accumulator, result to accumulator, update carry, digit carry, zero.
// [RULE_02] AND accumulator with addressed file register; only the zero flag changes.
// [RULE_03] Destination bit 0 writes the accumulator, 1 writes the file register back.
// [RULE_04] Add accumulator and file register to chosen destination; update all three flags.
// [RULE_05] Bit clear zeroes the indexed bit only; no flag changes.
// [RULE_06] AND immediate with accumulator into accumulator; only zero flag changes.
// [RULE_07] Bit set forces the indexed bit to one; no flag changes.
// [RULE_08] Skip-when-one: if bit is one, next instruction becomes a no-operation.
// [RULE_09] Skip-when-zero: if bit is zero, next instruction becomes a no-operation.
// [RULE_10] Clear-file writes 00h to the file register and sets zero.
// [RULE_11] Zero flag follows result equal zero; unlisted flags keep their values.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module mcu_add_and_bit_ops #(
   parameter int FILE_DEPTH = mcu_alu_pkg::FILE_DEPTH
) (
   input  wire  logic             clock_i,
   input  wire  logic             sys_rst_i,
   input  wire  logic             op_valid_i,
   input  wire  mcu_alu_pkg::op_t op_code_i,
   input  wire  logic [6:0]       op_file_addr_i,
   input  wire  logic [2:0]       op_bit_i,
   input  wire  logic [7:0]       op_imm_i,
   input  wire  logic             op_dest_i,
   input  wire  logic [7:0]       addr_i,
   input  wire  logic [7:0]       wr_data_i,
   input  wire  logic             wr_i,
   input  wire  logic             rd_i,
   output logic [7:0]             rd_data_o,
   output logic [7:0]             acc_o,
   output logic                   carry_o,
   output logic                   digit_carry_flag_o,
   output logic                   zero_o,
   output logic                   skip_taken_o,
   output logic                   squashed_o
);

   initial begin
      if (FILE_DEPTH != 128) begin
         $error("mcu_add_and_bit_ops: the 7-bit file address needs 128");
      end
   end

   logic [7:0] acc_reg;
   logic       carry_reg;
   logic       dc_reg;
   logic       zero_reg;
   logic       skip_pending_reg;
   logic       skip_taken_reg;
   logic       squashed_reg;
   logic [7:0] rd_data_reg;

   logic [7:0] file_rd;
   logic [7:0] bus_rd;
   logic [7:0] alu_result;
   logic       alu_carry;
   logic       alu_dc;
   logic       alu_to_acc;
   logic       alu_to_file;
   logic       alu_upd_arith;
   logic       alu_upd_zero;
   logic       alu_skip;
   logic       issue;
   logic       squash;
   logic       bus_file;
   logic       exec_file_wr;
   logic       mem_wr_en;
   logic [6:0] mem_wr_addr;
   logic [7:0] mem_wr_data;

   // An instruction that follows a taken skip is swallowed as a no-operation.
   assign issue  = op_valid_i & ~skip_pending_reg;
   assign squash = op_valid_i & skip_pending_reg;

   mcu_alu_core u_alu (
      .op_i        (op_code_i),
      .acc_i       (acc_reg),
      .file_i      (file_rd),
      .imm_i       (op_imm_i),
      .bit_idx_i   (op_bit_i),
      .dest_file_i (op_dest_i),
      .result_o    (alu_result),
      .carry_o     (alu_carry),
      .dc_o        (alu_dc),
      .to_acc_o    (alu_to_acc),
      .to_file_o   (alu_to_file),
      .upd_arith_o (alu_upd_arith),
      .upd_zero_o  (alu_upd_zero),
      .skip_o      (alu_skip)
   );

   // Execution owns the write port; a software write in the same cycle is lost.
   assign bus_file     = ~addr_i[7];
   assign exec_file_wr = issue & alu_to_file; // [RULE_03]
   assign mem_wr_en    = exec_file_wr | (wr_i & bus_file);
   assign mem_wr_addr  = exec_file_wr ? op_file_addr_i : addr_i[6:0];
   assign mem_wr_data  = exec_file_wr ? alu_result : wr_data_i;

   mcu_file_ram #(
      .DEPTH  (FILE_DEPTH),
      .ADDR_W (mcu_alu_pkg::FILE_ADDR_W)
   ) u_ram (
      .clock_i     (clock_i),
      .wr_en_i     (mem_wr_en),
      .wr_addr_i   (mem_wr_addr),
      .wr_data_i   (mem_wr_data),
      .rd_a_addr_i (op_file_addr_i),
      .rd_a_data_o (file_rd),
      .rd_b_addr_i (addr_i[6:0]),
      .rd_b_data_o (bus_rd)
   );

   // Accumulator; execution takes priority over a software write.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_reg <= mcu_alu_pkg::ACC_RST;
      end else if (issue && alu_to_acc) begin
         acc_reg <= alu_result; // [RULE_01] [RULE_03] [RULE_06]
      end else if (wr_i && addr_i == mcu_alu_pkg::ACC_ADDR) begin
         acc_reg <= wr_data_i;
      end
   end

   // Carry and digit carry change on the two add operations and on a software write to the status register.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         carry_reg <= mcu_alu_pkg::STATUS_RST[mcu_alu_pkg::CARRY_POS];
         dc_reg    <= mcu_alu_pkg::STATUS_RST[mcu_alu_pkg::DC_POS];
      end else if (issue && alu_upd_arith) begin
         carry_reg <= alu_carry; // [RULE_01] [RULE_04]
         dc_reg    <= alu_dc;
      end else if (wr_i && addr_i == mcu_alu_pkg::STATUS_ADDR) begin
         carry_reg <= wr_data_i[mcu_alu_pkg::CARRY_POS];
         dc_reg    <= wr_data_i[mcu_alu_pkg::DC_POS];
      end
   end

   // Zero flag; clear-file always yields zero, so it is always set there.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         zero_reg <= mcu_alu_pkg::STATUS_RST[mcu_alu_pkg::ZERO_POS];
      end else if (issue && alu_upd_zero) begin
         zero_reg <= (alu_result == 8'h00); // [RULE_11] [RULE_10] [RULE_02]
      end else if (wr_i && addr_i == mcu_alu_pkg::STATUS_ADDR) begin
         zero_reg <= wr_data_i[mcu_alu_pkg::ZERO_POS];
      end
   end

   // A taken test arms the pending skip until the next instruction arrives.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         skip_pending_reg <= 1'b0;
      end else if (issue && alu_skip) begin
         skip_pending_reg <= 1'b1; // [RULE_08] [RULE_09]
      end else if (squash) begin
         skip_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         skip_taken_reg <= 1'b0;
         squashed_reg   <= 1'b0;
      end else begin
         skip_taken_reg <= issue & alu_skip;
         squashed_reg   <= squash; // [RULE_08] [RULE_09]
      end
   end

   // Read data stand in the cycle after the read strobe only.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_data_reg <= 8'h00;
      end else if (!rd_i) begin
         rd_data_reg <= 8'h00;
      end else if (bus_file) begin
         rd_data_reg <= bus_rd;
      end else if (addr_i == mcu_alu_pkg::ACC_ADDR) begin
         rd_data_reg <= acc_reg;
      end else if (addr_i == mcu_alu_pkg::STATUS_ADDR) begin
         rd_data_reg <= {5'h00, zero_reg, dc_reg, carry_reg};
      end else begin
         rd_data_reg <= 8'h00;
      end
   end

   assign rd_data_o          = rd_data_reg;
   assign acc_o              = acc_reg;
   assign carry_o            = carry_reg;
   assign digit_carry_flag_o = dc_reg;
   assign zero_o             = zero_reg;
   assign skip_taken_o       = skip_taken_reg;
   assign squashed_o         = squashed_reg;

   // Checks on the execution behaviour.
   function automatic logic [7:0] one_hot(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction

   sequence s_issue(mcu_alu_pkg::op_t op);
      issue && op_code_i == op;
   endsequence

   sequence s_flags_hold;
      carry_o == $past(carry_o) && digit_carry_flag_o == $past(digit_carry_flag_o)
      && zero_o == $past(zero_o);
   endsequence

   property p_add_imm;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::add_immediate_to_acc) |=>
         {carry_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(op_imm_i)}
         && zero_o == (acc_o == 8'h00);
   endproperty
   a_add_imm: assert property (p_add_imm) // [RULE_01]
      else $error("add immediate result or carry wrong");

   property p_and_file;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::and_acc_with_file) and !op_dest_i |=>
         acc_o == ($past(acc_reg) & $past(file_rd))
         && carry_o == $past(carry_o)
         && digit_carry_flag_o == $past(digit_carry_flag_o);
   endproperty
   a_and_file: assert property (p_and_file) // [RULE_02]
      else $error("AND with file result or flags wrong");

   property p_dest_file;
      @(posedge clock_i) disable iff (sys_rst_i)
      issue && op_dest_i && (op_code_i == mcu_alu_pkg::add_acc_to_file
         || op_code_i == mcu_alu_pkg::and_acc_with_file) && !wr_i
      |-> mem_wr_en && mem_wr_addr == op_file_addr_i ##1 acc_o == $past(acc_o);
   endproperty
   a_dest_file: assert property (p_dest_file) // [RULE_03]
      else $error("destination one must write the file register only");

   property p_add_file;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::add_acc_to_file) and !op_dest_i |=>
         {carry_o, acc_o} == {1'b0, $past(acc_o)} + {1'b0, $past(file_rd)}
         && digit_carry_flag_o ==
            ({1'b0, $past(acc_o[3:0])} + {1'b0, $past(file_rd[3:0])} > 5'hf);
   endproperty
   a_add_file: assert property (p_add_file) // [RULE_04]
      else $error("add with file result or flags wrong");

   property p_bit_clear;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::file_bit_clear) |->
         mem_wr_en && mem_wr_data == (file_rd & ~one_hot(op_bit_i))
         ##1 s_flags_hold;
   endproperty
   a_bit_clear: assert property (p_bit_clear) // [RULE_05]
      else $error("bit clear wrote a wrong value or moved a flag");

   property p_and_imm;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::and_immediate_with_acc) |=>
         acc_o == ($past(acc_o) & $past(op_imm_i))
         && carry_o == $past(carry_o)
         && digit_carry_flag_o == $past(digit_carry_flag_o);
   endproperty
   a_and_imm: assert property (p_and_imm) // [RULE_06]
      else $error("AND immediate result or flags wrong");

   property p_bit_set;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::file_bit_set) |->
         mem_wr_en && mem_wr_data == (file_rd | one_hot(op_bit_i))
         ##1 s_flags_hold;
   endproperty
   a_bit_set: assert property (p_bit_set) // [RULE_07]
      else $error("bit set wrote a wrong value or moved a flag");

   property p_skip_one;
      @(posedge clock_i) disable iff (sys_rst_i)
      (s_issue(mcu_alu_pkg::skip_when_bit_one)
         and |(file_rd & one_hot(op_bit_i)))
      ##1 op_valid_i |-> squashed_o == 1'b0 ##1 (squashed_o and s_flags_hold);
   endproperty
   a_skip_one: assert property (p_skip_one) // [RULE_08]
      else $error("skip when one did not swallow the next instruction");

   property p_skip_zero;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::skip_when_bit_zero) |=>
         (skip_taken_o == $past(~|(file_rd & one_hot(op_bit_i))))
         and s_flags_hold;
   endproperty
   a_skip_zero: assert property (p_skip_zero) // [RULE_09]
      else $error("skip when zero decision or flags wrong");

   property p_swallow;
      @(posedge clock_i) disable iff (sys_rst_i)
      skip_taken_o && op_valid_i |=> (squashed_o && !skip_pending_reg
         && acc_o == $past(acc_o)) and s_flags_hold;
   endproperty
   a_swallow: assert property (p_swallow) // [RULE_08] [RULE_09]
      else $error("instruction after a taken skip was not discarded");

   property p_clear_file;
      @(posedge clock_i) disable iff (sys_rst_i)
      s_issue(mcu_alu_pkg::zero_file_register) |->
         mem_wr_en && mem_wr_data == 8'h00 ##1 zero_o;
   endproperty
   a_clear_file: assert property (p_clear_file) // [RULE_10]
      else $error("clear file did not write zero or set the zero flag");

   property p_zero_rule;
      @(posedge clock_i) disable iff (sys_rst_i)
      issue && alu_upd_zero && !alu_upd_arith |=> zero_o == $past(alu_result == 8'h00)
         && carry_o == $past(carry_o);
   endproperty
   a_zero_rule: assert property (p_zero_rule) // [RULE_11]
      else $error("zero flag does not follow the result");

endmodule
`default_nettype wire

// file: mcu_alu_pkg.sv
// Shared constants and operation codes for the add and bit-operation datapath.
package mcu_alu_pkg;

   localparam int DATA_W      = 8;
   localparam int FILE_ADDR_W = 7;
   localparam int FILE_DEPTH  = 128;
   localparam int BIT_IDX_W   = 3;
   localparam int BUS_ADDR_W  = 8;

   // Register map of the software port: 00h to 7Fh are the file registers.
   localparam logic [7:0] ACC_ADDR    = 8'h80;
   localparam logic [7:0] STATUS_ADDR = 8'h81;

   // Field positions inside the status register.
   localparam int CARRY_POS = 0;
   localparam int DC_POS    = 1;
   localparam int ZERO_POS  = 2;

   // Reset values and the clear-file value.
   localparam logic [7:0] ACC_RST    = 8'h00;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [7:0] CLEAR_VAL  = 8'h00;

   typedef enum logic [3:0] {
      add_immediate_to_acc,
      add_acc_to_file,
      and_immediate_with_acc,
      and_acc_with_file,
      file_bit_clear,
      file_bit_set,
      skip_when_bit_one,
      skip_when_bit_zero,
      zero_file_register
   } op_t;

endpackage

// file: mcu_alu_core.sv
// Combinational result, flag and skip decision for one operation.
`timescale 1ns/1ps
`default_nettype none
module mcu_alu_core (
   input  wire  mcu_alu_pkg::op_t op_i,
   input  wire  logic [7:0]       acc_i,
   input  wire  logic [7:0]       file_i,
   input  wire  logic [7:0]       imm_i,
   input  wire  logic [2:0]       bit_idx_i,
   input  wire  logic             dest_file_i,
   output logic [7:0]             result_o,
   output logic                   carry_o,
   output logic                   dc_o,
   output logic                   to_acc_o,
   output logic                   to_file_o,
   output logic                   upd_arith_o,
   output logic                   upd_zero_o,
   output logic                   skip_o
);

   // Sum with carry out of bit 7 and out of bit 3, packed {c, dc, sum}.
   function automatic logic [9:0] add8(input logic [7:0] a,
                                       input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] lo;
      s  = {1'b0, a} + {1'b0, b};
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return {s[8], lo[4], s[7:0]};
   endfunction

   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      return 8'h01 << idx;
   endfunction

   logic [9:0] sum;
   logic       sel_bit;

   always_comb begin
      sum         = add8(acc_i, op_i == mcu_alu_pkg::add_immediate_to_acc
                                ? imm_i : file_i);
      sel_bit     = |(file_i & bit_mask(bit_idx_i));
      result_o    = 8'h00;
      carry_o     = sum[9];
      dc_o        = sum[8];
      to_acc_o    = 1'b0;
      to_file_o   = 1'b0;
      upd_arith_o = 1'b0;
      upd_zero_o  = 1'b0;
      skip_o      = 1'b0;
      unique case (op_i)
         mcu_alu_pkg::add_immediate_to_acc: begin
            result_o    = sum[7:0];
            to_acc_o    = 1'b1;
            upd_arith_o = 1'b1;
            upd_zero_o  = 1'b1;
         end
         mcu_alu_pkg::add_acc_to_file: begin
            result_o    = sum[7:0];
            to_acc_o    = ~dest_file_i;
            to_file_o   = dest_file_i;
            upd_arith_o = 1'b1;
            upd_zero_o  = 1'b1;
         end
         mcu_alu_pkg::and_immediate_with_acc: begin
            result_o   = acc_i & imm_i;
            to_acc_o   = 1'b1;
            upd_zero_o = 1'b1;
         end
         mcu_alu_pkg::and_acc_with_file: begin
            result_o   = acc_i & file_i;
            to_acc_o   = ~dest_file_i;
            to_file_o  = dest_file_i;
            upd_zero_o = 1'b1;
         end
         mcu_alu_pkg::file_bit_clear: begin
            result_o  = file_i & ~bit_mask(bit_idx_i);
            to_file_o = 1'b1;
         end
         mcu_alu_pkg::file_bit_set: begin
            result_o  = file_i | bit_mask(bit_idx_i);
            to_file_o = 1'b1;
         end
         mcu_alu_pkg::skip_when_bit_one: begin
            skip_o = sel_bit;
         end
         mcu_alu_pkg::skip_when_bit_zero: begin
            skip_o = ~sel_bit;
         end
         mcu_alu_pkg::zero_file_register: begin
            result_o   = mcu_alu_pkg::CLEAR_VAL;
            to_file_o  = 1'b1;
            upd_zero_o = 1'b1;
         end
         default: begin
            result_o = 8'h00;
         end
      endcase
   end

endmodule
`default_nettype wire

// file: mcu_file_ram.sv
// File-register array with two asynchronous read ports and one write port.
`timescale 1ns/1ps
`default_nettype none
module mcu_file_ram #(
   parameter int DEPTH  = 128,
   parameter int ADDR_W = 7
) (
   input  wire  logic              clock_i,
   input  wire  logic              wr_en_i,
   input  wire  logic [ADDR_W-1:0] wr_addr_i,
   input  wire  logic [7:0]        wr_data_i,
   input  wire  logic [ADDR_W-1:0] rd_a_addr_i,
   output logic [7:0]              rd_a_data_o,
   input  wire  logic [ADDR_W-1:0] rd_b_addr_i,
   output logic [7:0]              rd_b_data_o
);

   initial begin
      if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
         $error("mcu_file_ram: DEPTH does not fit ADDR_W");
      end
   end

   logic [7:0] mem [DEPTH];

   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   assign rd_a_data_o = mem[rd_a_addr_i];
   assign rd_b_data_o = mem[rd_b_addr_i];

endmodule
`default_nettype wire

// file: tb.sv
// Self-checking testbench for the add and bit-operation datapath.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
   n_tests++; \
   if ((gt) !== (ex)) begin \
      errors++; \
      $display("BAD %s exp %h got %h", nm, ex, gt); \
   end \
end
module tb;
   logic             clock_i        = 1'b0;
   logic             sys_rst_i      = 1'b1;
   logic             op_valid_i     = 1'b0;
   mcu_alu_pkg::op_t op_code_i      = mcu_alu_pkg::add_immediate_to_acc;
   logic [6:0]       op_file_addr_i = 7'h00;
   logic [2:0]       op_bit_i       = 3'h0;
   logic [7:0]       op_imm_i       = 8'h00;
   logic             op_dest_i      = 1'b0;
   logic [7:0]       addr_i         = 8'h00;
   logic [7:0]       wr_data_i      = 8'h00;
   logic             wr_i           = 1'b0;
   logic             rd_i           = 1'b0;
   logic [7:0]       rd_data_o;
   logic [7:0]       acc_o;
   logic             carry_o;
   logic             digit_carry_flag_o;
   logic             zero_o;
   logic             skip_taken_o;
   logic             squashed_o;
   wire  logic [2:0] fl;
   wire  logic [1:0] pl;
   logic [7:0]       mr [0:127];
   logic [7:0]       w;
   logic             c;
   logic             dc;
   logic             z;
   logic             skp;
   logic [7:0]       rd_q [$];
   logic [12:0]      op_q [$];
   logic             rd_seen        = 1'b0;
   logic             op_seen        = 1'b0;
   logic [7:0]       er;
   logic [12:0]      eo;
   logic [15:0]      adds [5] = '{16'hff01, 16'h0f01, 16'h0000,
                                  16'h8080, 16'h7f7f};
   int               seed           = 80796;
   int               errors         = 0;
   int               n_tests        = 0;

   assign fl = {carry_o, digit_carry_flag_o, zero_o};
   assign pl = {skip_taken_o, squashed_o};

   always #4 clock_i = ~clock_i;

   mcu_add_and_bit_ops #(
      .FILE_DEPTH(mcu_alu_pkg::FILE_DEPTH)
   ) mcu_add_and_bit_ops_inst (
      .clock_i           (clock_i),
      .sys_rst_i         (sys_rst_i),
      .op_valid_i        (op_valid_i),
      .op_code_i         (op_code_i),
      .op_file_addr_i    (op_file_addr_i),
      .op_bit_i          (op_bit_i),
      .op_imm_i          (op_imm_i),
      .op_dest_i         (op_dest_i),
      .addr_i            (addr_i),
      .wr_data_i         (wr_data_i),
      .wr_i              (wr_i),
      .rd_i              (rd_i),
      .rd_data_o         (rd_data_o),
      .acc_o             (acc_o),
      .carry_o           (carry_o),
      .digit_carry_flag_o(digit_carry_flag_o),
      .zero_o            (zero_o),
      .skip_taken_o      (skip_taken_o),
      .squashed_o        (squashed_o)
   );

   task automatic tally_and_finish;
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [7:0] rd_exp(input logic [7:0] a);
      if (a < 8'h80)
         return mr[a[6:0]];
      if (a == mcu_alu_pkg::ACC_ADDR)
         return w;
      if (a == mcu_alu_pkg::STATUS_ADDR)
         return {5'h00, z, dc, c};
      return 8'h00;
   endfunction

   task automatic drive(input logic v, input logic wr, input logic rd,
                        input logic [7:0] a, input logic [7:0] dt);
      @(posedge clock_i);
      op_valid_i <= v;
      wr_i <= wr;
      rd_i <= rd;
      addr_i <= a;
      wr_data_i <= dt;
   endtask

   task automatic idle;
      drive(1'b0, 1'b0, 1'b0, addr_i, wr_data_i);
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] dt);
      if (a < 8'h80)
         mr[a[6:0]] = dt;
      else if (a == mcu_alu_pkg::ACC_ADDR)
         w = dt;
      else if (a == mcu_alu_pkg::STATUS_ADDR)
         {z, dc, c} = dt[2:0];
      drive(1'b0, 1'b1, 1'b0, a, dt);
   endtask

   task automatic bus_rd(input logic [7:0] a);
      rd_q.push_back(rd_exp(a));
      drive(1'b0, 1'b0, 1'b1, a, wr_data_i);
   endtask

   // Reference model: a pending taken test discards the next instruction.
   task automatic run_op(input mcu_alu_pkg::op_t o, input logic [6:0] f,
                         input logic [2:0] b, input logic [7:0] k,
                         input logic d);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] x;
      logic       st;
      logic       sq;
      st = 1'b0;
      sq = skp;
      x = (o == mcu_alu_pkg::add_immediate_to_acc ||
           o == mcu_alu_pkg::and_immediate_with_acc) ? k : mr[f];
      if (!sq) begin
         case (o)
            mcu_alu_pkg::add_immediate_to_acc,
            mcu_alu_pkg::add_acc_to_file: begin
               s = {1'b0, w} + {1'b0, x};
               h = {1'b0, w[3:0]} + {1'b0, x[3:0]};
               c = s[8];
               dc = h[4];
               z = (s[7:0] == 8'h00);
               if (o == mcu_alu_pkg::add_acc_to_file && d)
                  mr[f] = s[7:0];
               else
                  w = s[7:0];
            end
            mcu_alu_pkg::and_immediate_with_acc,
            mcu_alu_pkg::and_acc_with_file: begin
               z = ((w & x) == 8'h00);
               if (o == mcu_alu_pkg::and_acc_with_file && d)
                  mr[f] = w & x;
               else
                  w = w & x;
            end
            mcu_alu_pkg::file_bit_clear: mr[f][b] = 1'b0;
            mcu_alu_pkg::file_bit_set: mr[f][b] = 1'b1;
            mcu_alu_pkg::skip_when_bit_one: st = mr[f][b];
            mcu_alu_pkg::skip_when_bit_zero: st = ~mr[f][b];
            default: begin
               mr[f] = 8'h00;
               z = 1'b1;
            end
         endcase
      end
      skp = st;
      op_q.push_back({w, c, dc, z, st, sq});
      drive(1'b1, 1'b0, 1'b0, addr_i, wr_data_i);
      op_code_i <= o;
      op_file_addr_i <= f;
      op_bit_i <= b;
      op_imm_i <= k;
      op_dest_i <= d;
   endtask

   always @(posedge clock_i) begin
      rd_seen <= rd_i;
      op_seen <= op_valid_i;
   end

   always @(negedge clock_i) begin
      if (rd_seen === 1'b1) begin
         er = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx;
         `CHK("rd_data_o", er, rd_data_o)
      end
      if (op_seen === 1'b1) begin
         eo = (op_q.size() > 0) ? op_q.pop_front() : 13'hxxxx;
         `CHK("acc_o", eo[12:5], acc_o)
         `CHK("flags", eo[4:2], fl)
         `CHK("pulses", eo[1:0], pl)
      end
   end

   initial begin
      repeat (100000) @(posedge clock_i);
      errors++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] r;
      int          i;
      w = 8'h00;
      {c, dc, z, skp} = 4'h0;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      bus_rd(mcu_alu_pkg::ACC_ADDR);
      bus_rd(mcu_alu_pkg::STATUS_ADDR);
      for (i = 0; i < 128; i++)
         bus_wr(8'(i), 8'($random(seed)));
      for (i = 0; i < 128; i++)
         bus_rd(8'(i));
      bus_wr(8'h9a, 8'h55);
      bus_rd(8'h9a);
      bus_rd(8'hff);
      // Carry, digit carry and zero corners of the immediate add.
      foreach (adds[j]) begin
         bus_wr(mcu_alu_pkg::ACC_ADDR, adds[j][15:8]);
         run_op(mcu_alu_pkg::add_immediate_to_acc, 7'h00, 3'h0,
                adds[j][7:0], 1'b0);
      end
      bus_wr(8'h7f, 8'h88);
      bus_wr(mcu_alu_pkg::ACC_ADDR, 8'h78);
      run_op(mcu_alu_pkg::add_acc_to_file, 7'h7f, 3'h0, 8'h00, 1'b1);
      bus_rd(8'h7f);
      run_op(mcu_alu_pkg::add_acc_to_file, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::and_acc_with_file, 7'h7f, 3'h0, 8'h00, 1'b1);
      run_op(mcu_alu_pkg::and_acc_with_file, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::and_immediate_with_acc, 7'h00, 3'h0, 8'hff, 1'b0);
      run_op(mcu_alu_pkg::and_immediate_with_acc, 7'h00, 3'h0, 8'h00, 1'b0);
      bus_wr(mcu_alu_pkg::STATUS_ADDR, 8'h07);
      run_op(mcu_alu_pkg::file_bit_set, 7'h7f, 3'h7, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::file_bit_clear, 7'h7f, 3'h0, 8'h00, 1'b0);
      bus_rd(8'h7f);
      bus_rd(mcu_alu_pkg::STATUS_ADDR);
      // Taken tests, a gap before the discarded one, and a test discarded.
      bus_wr(8'h7f, 8'h80);
      run_op(mcu_alu_pkg::skip_when_bit_one, 7'h7f, 3'h7, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::add_immediate_to_acc, 7'h00, 3'h0, 8'h01, 1'b0);
      run_op(mcu_alu_pkg::skip_when_bit_zero, 7'h7f, 3'h0, 8'h00, 1'b0);
      repeat (3) idle();
      run_op(mcu_alu_pkg::zero_file_register, 7'h7f, 3'h0, 8'h00, 1'b0);
      bus_rd(8'h7f);
      run_op(mcu_alu_pkg::skip_when_bit_one, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::zero_file_register, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::skip_when_bit_zero, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::skip_when_bit_zero, 7'h7f, 3'h0, 8'h00, 1'b0);
      run_op(mcu_alu_pkg::add_immediate_to_acc, 7'h00, 3'h0, 8'h01, 1'b0);
      // Second reset: accumulator and flags clear, file contents stay.
      repeat (2) idle();
      @(posedge clock_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      w = 8'h00;
      {c, dc, z, skp} = 4'h0;
      bus_rd(mcu_alu_pkg::ACC_ADDR);
      bus_rd(mcu_alu_pkg::STATUS_ADDR);
      bus_rd(8'h7f);
      for (i = 0; i < 800; i++) begin
         r = $random(seed);
         if (r[1:0] == 2'h0)
            idle();
         else if (r[1:0] == 2'h1 && r[31])
            bus_wr(r[15:8], r[23:16]);
         else if (r[1:0] == 2'h1)
            bus_rd(r[15:8]);
         else
            run_op(mcu_alu_pkg::op_t'(r[19:16] % 4'd9), r[26:20],
                   r[29:27], r[15:8], r[30]);
      end
      repeat (3) idle();
      `CHK("drained", 1'b1, (rd_q.size() == 0 && op_q.size() == 0))
      tally_and_finish();
   end
endmodule
`default_nettype wire
